// ---- rtl/timer_one_counter.sv ----
// 16-bit timer/counter with prescaler, shared pin control and avalon-mm register slave
`timescale 1ns/1ns
`include "timer_one_cfg.svh"

module timer_one_counter #(
  parameter int INSTR_DIV  = `INSTR_DIV,
  parameter int PRESCALE_W = 3
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // shared port pins, index 0 is port bit 1, index 1 is port bit 2
  input  wire logic [1:0]  shared_pin_in,
  output logic      [1:0]  shared_pin_out,
  output logic      [1:0]  shared_pin_oe_n,
  output logic             osc_amp_enable,
  // core side
  input  wire logic        sleep_active,
  input  wire logic [3:0]  compare_mode,
  input  wire logic        compare_trigger,
  output logic             overflow_irq
);

  localparam int QW = $clog2(INSTR_DIV);

  logic [`CONTROL_HI:0]   control_reg;
  logic [15:0]            count_reg;
  logic                   flag_reg;
  logic                   irq_en_reg;
  logic                   fw_clk_reg;
  logic                   pin_dir_reg;
  logic [1:0]             port_latch_reg;
  logic [1:0]             port_dir_reg;
  logic                   ack_reg;
  logic [1:0]             pin_meta_reg;
  logic [1:0]             pin_sync_reg;
  logic                   ext_prev_reg;
  logic                   edge_pend_reg;
  logic [QW-1:0]          quarter_reg;
  logic [PRESCALE_W-1:0]  pre_reg;
  timer_one_pkg::clk_mode_type mode;
  logic                   run;
  logic                   counter_sel;
  logic                   osc_on;
  logic                   sync_dis;
  logic [1:0]             prescale;
  logic [PRESCALE_W-1:0]  ratio_m1;
  logic                   ext_level;
  logic                   ext_rise;
  logic                   instr_tick;
  logic                   src_tick;
  logic                   count_tick;
  logic                   trig;
  logic                   count_wr;
  logic                   flag_set;
  logic [1:0]             port_rd;
  logic                   fw_rd;
  logic [7:0]             read_value;
  logic [7:0]             reg_idx;
  logic [7:0]             wbyte;
  logic                   wr_lane;
  logic                   wr_low;
  logic                   wr_high;

  //////////////////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the request completes
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign reg_idx         = avs_address[9:2];
  assign wbyte           = avs_writedata[7:0];
  assign wr_lane         = avs_write & ack_reg & avs_byteenable[0];
  assign wr_low          = wr_lane & (reg_idx == `IDX_COUNT_LOW);
  assign wr_high         = wr_lane & (reg_idx == `IDX_COUNT_HIGH);
  assign count_wr        = wr_low | wr_high;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  always_comb begin
    case (reg_idx)
      `IDX_COUNT_LOW:  read_value = count_reg[7:0];
      `IDX_COUNT_HIGH: read_value = count_reg[15:8];
      `IDX_CONTROL:    read_value = {2'h0, control_reg};
      `IDX_FLAG:       read_value = {7'h00, flag_reg};
      `IDX_ENABLE:     read_value = {7'h00, irq_en_reg};
      `IDX_PIN_DATA:   read_value = {7'h00, fw_rd};
      `IDX_PIN_DIR:    read_value = {7'h00, pin_dir_reg};
      `IDX_PORT_DATA:  read_value = {5'h00, port_rd, 1'b0};
      `IDX_PORT_DIR:   read_value = {5'h00, port_dir_reg, 1'b0};
      default:         read_value = 8'h00;
    endcase
  end

  // read data is captured in the wait cycle and stands through the completing edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= {16'h0000, 8'h00, read_value};
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      control_reg <= `CONTROL_RESET;
    end else if (wr_lane & (reg_idx == `IDX_CONTROL)) begin
      control_reg <= wbyte[`CONTROL_HI:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_en_reg <= 1'b0;
    end else if (wr_lane & (reg_idx == `IDX_ENABLE)) begin
      irq_en_reg <= wbyte[`BIT_IRQ_EN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fw_clk_reg  <= 1'b0;
      pin_dir_reg <= `PIN_DIR_RESET;
    end else begin
      if (wr_lane & (reg_idx == `IDX_PIN_DATA)) begin
        fw_clk_reg <= wbyte[`BIT_FW_CLK];
      end
      if (wr_lane & (reg_idx == `IDX_PIN_DIR)) begin
        pin_dir_reg <= wbyte[`BIT_FW_CLK];
      end
    end
  end

  // port writes only ever reach the latches; pin drive is decided below
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_latch_reg <= `PORT_LATCH_RESET;
      port_dir_reg   <= `PORT_DIR_RESET;
    end else begin
      if (wr_lane & (reg_idx == `IDX_PORT_DATA)) begin
        port_latch_reg <= wbyte[2:1];
      end
      if (wr_lane & (reg_idx == `IDX_PORT_DIR)) begin
        port_dir_reg <= wbyte[2:1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // mode decode and clock sources
  assign run         = control_reg[`BIT_COUNT_EN];
  assign counter_sel = control_reg[`BIT_CLK_SEL];
  assign osc_on      = control_reg[`BIT_OSC_EN];
  assign sync_dis    = control_reg[`BIT_SYNC_DIS];
  assign prescale    = control_reg[`PRESCALE_HI:`PRESCALE_LO];

  always_comb begin
    if (!counter_sel) begin
      mode = run ? timer_one_pkg::SRC_TIMER : timer_one_pkg::SRC_OFF;
    end else begin
      mode = osc_on ? timer_one_pkg::SRC_CNT_OSC : timer_one_pkg::SRC_CNT_PIN;
    end
  end

  // amplifier stays on through sleep so the crystal clock keeps going
  assign osc_amp_enable = osc_on;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      pin_meta_reg <= shared_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // firmware source is internal, so it skips the synchroniser
  assign ext_level = (mode == timer_one_pkg::SRC_CNT_PIN && !pin_dir_reg) ?
                     fw_clk_reg : pin_sync_reg[0];
  assign ext_rise  = ext_level & ~ext_prev_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_level;
    end
  end

  // instruction clock halts in sleep
  assign instr_tick = ~sleep_active & (quarter_reg == QW'(INSTR_DIV - 1));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      quarter_reg <= '0;
    end else if (!sleep_active) begin
      quarter_reg <= instr_tick ? '0 : quarter_reg + QW'(1);
    end
  end

  // synchronised edges wait for the next instruction tick; async ones count at once
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      edge_pend_reg <= 1'b0;
    end else if (ext_rise & ~instr_tick & ~sync_dis) begin
      edge_pend_reg <= 1'b1;
    end else if (instr_tick | sync_dis) begin
      edge_pend_reg <= 1'b0;
    end
  end

  always_comb begin
    case (mode)
      timer_one_pkg::SRC_TIMER:   src_tick = instr_tick;
      timer_one_pkg::SRC_CNT_PIN,
      timer_one_pkg::SRC_CNT_OSC: begin
        src_tick = sync_dis ? ext_rise : (instr_tick & (edge_pend_reg | ext_rise));
      end
      default:                    src_tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // prescaler, count and overflow flag
  assign ratio_m1   = PRESCALE_W'((4'h1 << prescale) - 4'h1);
  assign count_tick = run & src_tick & (pre_reg == ratio_m1);
  assign trig       = compare_trigger & (compare_mode == `TRIG_RESET_CODE);
  assign flag_set   = count_tick & (count_reg == `COUNT_MAX) & ~count_wr & ~trig;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pre_reg <= '0;
    end else if (count_wr | ~run | trig) begin
      pre_reg <= '0;
    end else if (src_tick) begin
      pre_reg <= (pre_reg == ratio_m1) ? '0 : pre_reg + PRESCALE_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_reg <= `COUNT_RESET;
    end else if (count_wr) begin
      if (wr_low) begin
        count_reg[7:0] <= wbyte;
      end
      if (wr_high) begin
        count_reg[15:8] <= wbyte;
      end
    end else if (trig) begin
      count_reg <= `COUNT_ZERO;
    end else if (count_tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // a rollover in the clearing cycle still sets the flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (wr_lane & (reg_idx == `IDX_FLAG)) begin
      flag_reg <= wbyte[`BIT_FLAG];
    end
  end

  assign overflow_irq = flag_reg & irq_en_reg;

  //////////////////////////////////////////////////////////////////////////////////////////
  // shared pins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shared_pin_out  <= 2'h0;
      shared_pin_oe_n <= 2'h3;
    end else if (osc_on) begin
      shared_pin_out  <= port_latch_reg;
      shared_pin_oe_n <= 2'h3;
    end else if (counter_sel) begin
      shared_pin_out  <= {port_latch_reg[1], fw_clk_reg};
      shared_pin_oe_n <= {port_dir_reg[1], pin_dir_reg};
    end else begin
      shared_pin_out  <= port_latch_reg;
      shared_pin_oe_n <= port_dir_reg;
    end
  end

  always_comb begin
    port_rd = port_dir_reg & pin_sync_reg | ~port_dir_reg & port_latch_reg;
    if (osc_on && counter_sel) begin
      port_rd = ~port_dir_reg & port_latch_reg;
    end else if (counter_sel) begin
      port_rd[0] = ~port_dir_reg[0] & port_latch_reg[0];
    end
  end

  always_comb begin
    if (osc_on && counter_sel) begin
      fw_rd = 1'b0;
    end else if (counter_sel && pin_dir_reg) begin
      fw_rd = pin_sync_reg[0];
    end else begin
      fw_rd = fw_clk_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  roll_over_a: assert property (
    (count_tick && count_reg == `COUNT_MAX && !count_wr && !trig)
      |=> (count_reg == `COUNT_ZERO && flag_reg))
    else $error("rollover did not zero count and set flag");
  irq_gate_a: assert property (
    overflow_irq |-> (irq_en_reg && flag_reg))
    else $error("interrupt request without enable");
  stop_hold_a: assert property (
    (!run && !count_wr && !trig) |=> $stable(count_reg))
    else $error("count moved while disabled");
  timer_rate_a: assert property (
    (mode == timer_one_pkg::SRC_TIMER && prescale == 2'h0 && count_tick)
      |=> !count_tick [*3])
    else $error("timer counted faster than once per instruction cycle");
  async_edge_a: assert property (
    (run && counter_sel && sync_dis && prescale == 2'h0 && ext_rise && !count_wr && !trig)
      |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("async counter missed an external rising edge");
  osc_inputs_a: assert property (
    osc_on |=> shared_pin_oe_n == 2'h3)
    else $error("shared pin driven while oscillator enabled");
  fw_drive_a: assert property (
    (counter_sel && !osc_on && !pin_dir_reg)
      |=> (!shared_pin_oe_n[0] && shared_pin_out[0] == $past(fw_clk_reg)))
    else $error("firmware clock bit not driving the pin");
  trig_clear_a: assert property (
    (trig && !count_wr && !(wr_lane && reg_idx == `IDX_FLAG))
      |=> (count_reg == `COUNT_ZERO && !$rose(flag_reg)))
    else $error("trigger did not clear count or set the flag");
  write_wins_a: assert property (
    (trig && wr_low) |=> count_reg[7:0] == $past(wbyte))
    else $error("trigger overrode a count write");
  osc_read_a: assert property (
    (osc_on && counter_sel) |-> ((port_rd & port_dir_reg) == 2'h0 && !fw_rd))
    else $error("input shared pin read nonzero in crystal mode");
  sleep_osc_a: assert property (
    (sleep_active && mode == timer_one_pkg::SRC_CNT_OSC && count_tick && !count_wr && !trig)
      |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("crystal counter did not advance in sleep");

  rollover_c: cover property (flag_set);
  trigger_c: cover property (trig && count_reg != `COUNT_ZERO);
  osc_count_c: cover property (mode == timer_one_pkg::SRC_CNT_OSC && count_tick);
  fw_count_c: cover property (counter_sel && !pin_dir_reg && count_tick);
  sleep_count_c: cover property (sleep_active && count_tick);

endmodule : timer_one_counter

// ---- rtl/timer_one_cfg.svh ----
// register indices, bit positions, reset values and codes of the 16-bit timer/counter
`ifndef TIMER_ONE_CFG_SVH
`define TIMER_ONE_CFG_SVH

// register indices; byte address is four times the index
`define IDX_PORT_DATA    8'h06
`define IDX_PIN_DATA     8'h07
`define IDX_FLAG         8'h0C
`define IDX_COUNT_LOW    8'h0E
`define IDX_COUNT_HIGH   8'h0F
`define IDX_CONTROL      8'h10
`define IDX_PORT_DIR     8'h86
`define IDX_PIN_DIR      8'h87
`define IDX_ENABLE       8'h8C

// timer_one_control fields
`define BIT_COUNT_EN     0
`define BIT_CLK_SEL      1
`define BIT_SYNC_DIS     2
`define BIT_OSC_EN       3
`define PRESCALE_HI      5
`define PRESCALE_LO      4
`define CONTROL_HI       5

// single-bit fields of the flag, enable and pin data registers
`define BIT_FLAG         0
`define BIT_IRQ_EN       0
`define BIT_FW_CLK       0

// reset values
`define CONTROL_RESET    6'h00
`define COUNT_RESET      16'h0000
`define PORT_DIR_RESET   2'h3
`define PORT_LATCH_RESET 2'h0
`define PIN_DIR_RESET    1'h1

// count limits and trigger code
`define COUNT_MAX        16'hFFFF
`define COUNT_ZERO       16'h0000
`define TRIG_RESET_CODE  4'hB

// main clock cycles per instruction cycle
`define INSTR_DIV        4

`endif

// ---- rtl/timer_one_pkg.sv ----
// types of the 16-bit timer/counter
package timer_one_pkg;

  // clock source decode, gray coded along off, timer, pin counter, crystal counter
  typedef enum logic [1:0] {
    SRC_OFF     = 2'h0,
    SRC_TIMER   = 2'h1,
    SRC_CNT_PIN = 2'h3,
    SRC_CNT_OSC = 2'h2
  } clk_mode_type;

endpackage : timer_one_pkg

// ---- test/ext_clock_model.sv ----
// behavioural external clock source or crystal driving the two shared pins
`timescale 1ns/1ns

module ext_clock_model #(
  parameter int HALF_NS = 200
) (
  // pin levels as the far side drives them, [0] clock, [1] crystal input side
  output logic [1:0] link_level
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle high between bursts: the clock stands still outside them
  initial begin
    link_level = 2'h1;
  end

  // the source keeps running whatever the core does, sleep included
  task automatic burst(input int n);
    #13;
    repeat (n) begin
      link_level <= 2'h2;
      #HALF_NS;
      link_level <= 2'h1;
      #HALF_NS;
    end
  endtask : burst
endmodule : ext_clock_model

// ---- test/tb_top.sv ----
// self-checking testbench of the 16-bit timer/counter over its register bus
`timescale 1ns/1ns
`include "timer_one_cfg.svh"

`define CHECK_EQ(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
  end \
end

module tb_top;
  logic        core_clk;
  logic        sys_rst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  shared_pin_out;
  logic [1:0]  shared_pin_oe_n;
  logic [1:0]  link_level;
  wire  [1:0]  pin_level;
  logic        osc_amp_enable;
  logic        sleep_active;
  logic [3:0]  compare_mode;
  logic        compare_trigger;
  logic        overflow_irq;
  int          fails;
  int          comparisons;
  logic [7:0]  q;
  logic [7:0]  rst_idx [8] = '{8'h10, 8'h0E, 8'h0F, 8'h0C, 8'h8C, 8'h87, 8'h86, 8'h20};
  logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h06, 8'h00};
  logic [7:0]  rate_ctl [5] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h05};
  int          rate_exp [5] = '{100, 50, 25, 12, 100};

  ////////////////////////////////////////////////////////////////////////////////
  // wire level: the design wins where it drives, else the far side
  assign pin_level = (shared_pin_oe_n & link_level) | (~shared_pin_oe_n & shared_pin_out);

  timer_one_counter timer_one_counter_i (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .shared_pin_in   (pin_level),
    .shared_pin_out  (shared_pin_out),
    .shared_pin_oe_n (shared_pin_oe_n),
    .osc_amp_enable  (osc_amp_enable),
    .sleep_active    (sleep_active),
    .compare_mode    (compare_mode),
    .compare_trigger (compare_trigger),
    .overflow_irq    (overflow_irq)
  );

  ext_clock_model ext_clock_model_i (
    .link_level (link_level)
  );

  initial begin
    core_clk = 1'h0;
  end

  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  // trg raises the trigger for the cycle in which the slave completes
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic trg);
    int n;
    n = 0;
    avs_address   <= {idx, 2'h0};
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge core_clk);
      n++;
      if (n == 1) begin
        compare_trigger <= trg;
      end
    end while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata[7:0];
    avs_write       <= 1'h0;
    avs_read        <= 1'h0;
    compare_trigger <= 1'h0;
    if (n >= 20) begin
      fails++;
      $display("MISMATCH %0t bus answer never came", $time);
      give_verdict();
    end
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'h1, idx, d, 1'h0);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    bus(1'h0, idx, 8'h00, 1'h0);
  endtask : rd

  task automatic zero_count();
    wr(`IDX_COUNT_HIGH, 8'h00);
    wr(`IDX_COUNT_LOW, 8'h00);
  endtask : zero_count

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    comparisons = 0;
    sys_rst = 1'h1;
    avs_address = 10'h000;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    sleep_active = 1'h0;
    compare_mode = 4'h0;
    compare_trigger = 1'h0;
    idle(16);
    sys_rst <= 1'h0;
    idle(1);
    // reset values, an unmapped index and reserved control bits
    for (int i = 0; i < 8; i++) begin
      rd(rst_idx[i]);
      `CHECK_EQ(q, rst_val[i])
    end
    wr(8'h20, 8'h5A);
    rd(8'h20);
    `CHECK_EQ(q, 8'h00)
    wr(`IDX_CONTROL, 8'hC0);
    rd(`IDX_CONTROL);
    `CHECK_EQ(q, 8'h00)
    // rollover, flag and interrupt mask
    wr(`IDX_COUNT_HIGH, 8'hFF);
    wr(`IDX_COUNT_LOW, 8'hFE);
    rd(`IDX_COUNT_HIGH);
    `CHECK_EQ(q, 8'hFF)
    wr(`IDX_CONTROL, 8'h01);
    q = 8'h00;
    for (int i = 0; i < 20 && q[0] !== 1'h1; i++) rd(`IDX_FLAG);
    `CHECK_EQ(q[0], 1'h1)
    wr(`IDX_CONTROL, 8'h00);
    rd(`IDX_COUNT_HIGH);
    `CHECK_EQ(q, 8'h00)
    `CHECK_EQ(overflow_irq, 1'h0)
    wr(`IDX_ENABLE, 8'h01);
    `CHECK_EQ(overflow_irq, 1'h1)
    wr(`IDX_ENABLE, 8'h00);
    `CHECK_EQ(overflow_irq, 1'h0)
    // stopped counter holds still
    rd(`IDX_COUNT_LOW);
    idle(40);
    begin
      logic [7:0] held;
      held = q;
      rd(`IDX_COUNT_LOW);
      `CHECK_EQ(q, held)
    end
    // timer rate per prescale code; sync bit ignored in timer mode
    for (int i = 0; i < 5; i++) begin
      zero_count();
      wr(`IDX_CONTROL, rate_ctl[i]);
      idle(400);
      wr(`IDX_CONTROL, 8'h00);
      rd(`IDX_COUNT_LOW);
      `CHECK_EQ(q >= rate_exp[i] - 2 && q <= rate_exp[i] + 2, 1'h1)
    end
    // pin counter, synchronised then asynchronous
    zero_count();
    wr(`IDX_CONTROL, 8'h03);
    ext_clock_model_i.burst(5);
    idle(10);
    rd(`IDX_COUNT_LOW);
    `CHECK_EQ(q, 8'h05)
    rd(`IDX_PIN_DATA);
    `CHECK_EQ(q, 8'h01)
    rd(`IDX_PORT_DATA);
    `CHECK_EQ(q & 8'h02, 8'h00)
    zero_count();
    wr(`IDX_CONTROL, 8'h07);
    ext_clock_model_i.burst(3);
    idle(10);
    rd(`IDX_COUNT_LOW);
    `CHECK_EQ(q, 8'h03)
    // firmware bit drives the clock pin
    wr(`IDX_PIN_DIR, 8'h00);
    zero_count();
    for (int i = 0; i < 3; i++) begin
      wr(`IDX_PIN_DATA, 8'h01);
      // pin outputs are registered one edge after the bit lands
      idle(1);
      `CHECK_EQ({shared_pin_oe_n[0], shared_pin_out[0]}, 2'h1)
      wr(`IDX_PIN_DATA, 8'h00);
    end
    idle(5);
    rd(`IDX_COUNT_LOW);
    `CHECK_EQ(q, 8'h03)
    wr(`IDX_PIN_DIR, 8'h01);
    // crystal counter, running through sleep
    wr(`IDX_PORT_DIR, 8'h00);
    wr(`IDX_PORT_DATA, 8'h06);
    wr(`IDX_CONTROL, 8'h0F);
    sleep_active <= 1'h1;
    idle(20);
    `CHECK_EQ(osc_amp_enable, 1'h1)
    `CHECK_EQ(shared_pin_oe_n, 2'h3)
    rd(`IDX_PORT_DATA);
    `CHECK_EQ(q & 8'h06, 8'h06)
    rd(`IDX_PIN_DATA);
    `CHECK_EQ(q, 8'h00)
    zero_count();
    ext_clock_model_i.burst(4);
    idle(10);
    rd(`IDX_COUNT_LOW);
    `CHECK_EQ(q, 8'h04)
    wr(`IDX_PORT_DIR, 8'h06);
    rd(`IDX_PORT_DATA);
    `CHECK_EQ(q & 8'h06, 8'h00)
    wr(`IDX_PORT_DIR, 8'h00);
    wr(`IDX_CONTROL, 8'h01);
    sleep_active <= 1'h0;
    idle(1);
    `CHECK_EQ(osc_amp_enable, 1'h0)
    `CHECK_EQ({shared_pin_oe_n, shared_pin_out}, 4'h3)
    // trigger reset, other codes, and a write winning over it
    wr(`IDX_CONTROL, 8'h00);
    wr(`IDX_COUNT_HIGH, 8'h12);
    wr(`IDX_COUNT_LOW, 8'h34);
    bus(1'h0, `IDX_COUNT_LOW, 8'h00, 1'h1);
    rd(`IDX_COUNT_LOW);
    `CHECK_EQ(q, 8'h34)
    compare_mode <= 4'hB;
    wr(`IDX_FLAG, 8'h00);
    bus(1'h0, `IDX_COUNT_LOW, 8'h00, 1'h1);
    rd(`IDX_COUNT_HIGH);
    `CHECK_EQ(q, 8'h00)
    rd(`IDX_FLAG);
    `CHECK_EQ(q, 8'h00)
    wr(`IDX_COUNT_HIGH, 8'h12);
    bus(1'h1, `IDX_COUNT_LOW, 8'h55, 1'h1);
    rd(`IDX_COUNT_LOW);
    `CHECK_EQ(q, 8'h55)
    rd(`IDX_COUNT_HIGH);
    `CHECK_EQ(q, 8'h12)
    give_verdict();
  end
endmodule : tb_top
